// ### lcd_drive_control_bench.sv
// self-checking bench: apb tasks and panel model around the block
// assumes 100 MHz pclk, no random stimulus
`timescale 1ns/100ps
`default_nettype none
module lcd_drive_control_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        scan_req, scan_dot, scan_valid, bias_power_on, reference_level_select;
  logic        frame_17_commons, expansion_driver_enable, sweep_on;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, contrast_level;
  logic [4:0]  scan_common, common_count;
  logic [5:0]  scan_column;
  logic [1:0]  segment_mode;
  logic [15:0] lit_seen, dark_seen, l0, d0;
  int          err_total, num_checks, cyc;
  ldc_lcd_drive_control u_ldc_lcd_drive_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .scan_req, .scan_common, .scan_column, .scan_dot, .scan_valid,
    .bias_power_on, .reference_level_select, .contrast_level, .common_count, .frame_17_commons,
    .segment_mode, .expansion_driver_enable);
  ldc_panel_model u_ldc_panel_model (.pclk, .presetn, .sweep_on, .scan_req, .scan_common, .scan_column, .scan_dot,
    .scan_valid, .lit_seen, .dark_seen);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // waits for pready without limit; the cycle ceiling ends a hung transfer
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // let dots fetched before the last write drain before the snapshot
  task automatic watch(input logic lit);
    repeat (4) @(posedge pclk);
    l0 = lit_seen;
    d0 = dark_seen;
    repeat (500) @(posedge pclk);
    chk({30'h0, lit_seen != l0, dark_seen != d0}, {30'h0, lit, !lit});
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run;
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    pstrb <= 4'hf;
    sweep_on <= 1'b0;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, ldc_pkg::power_duty_addr, 0);
    chk(rd, 32'h0);
    xfer(1'b0, ldc_pkg::override_addr, 0);
    chk(rd, 32'h4);
    chk({segment_mode, common_count, bias_power_on}, {2'b10, 5'h11, 1'b0});
    xfer(1'b1, ldc_pkg::contrast_addr, 32'h7);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, ldc_pkg::power_duty_addr, i);
      xfer(1'b0, ldc_pkg::power_duty_addr, 0);
      chk(rd, i);
      chk({bias_power_on, reference_level_select, frame_17_commons, common_count, contrast_level},
          {i[0], i[1], i[3:2] == 2'b00, i[3] ? 5'h08 : i[2] ? 5'h10 : 5'h11, i[0] ? 4'h7 : 4'h0});
      xfer(1'b1, ldc_pkg::override_addr, i);
      xfer(1'b0, ldc_pkg::override_addr, 0);
      chk(rd, i);
      chk({segment_mode, expansion_driver_enable}, {i[1] ? 2'b01 : i[2] ? 2'b10 : 2'b00, i[3]});
    end
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, ldc_pkg::contrast_addr, c);
      xfer(1'b0, ldc_pkg::contrast_addr, 0);
      chk({rd[3:0], contrast_level}, {c[3:0], c[3:0]});
    end
    pstrb <= 4'h0;
    xfer(1'b1, ldc_pkg::contrast_addr, 32'h7);
    pstrb <= 4'hf;
    xfer(1'b0, ldc_pkg::power_duty_addr, 0);
    chk(contrast_level, 32'hf);
    xfer(1'b1, ldc_pkg::power_duty_addr, 0);
    xfer(1'b0, ldc_pkg::contrast_addr, 0);
    chk({rd[3:0], contrast_level}, 32'hf0);
    xfer(1'b0, 18'h00010, 0);
    chk({er, rd}, {1'b1, 32'h0});
    for (int k = 0; k < 16'h0078; k++) begin
      xfer(1'b1, ldc_pkg::dmem_base_addr + 18'(4 * k), 0);
      xfer(1'b1, ldc_pkg::dmem_base_addr + 18'(4 * k + 16'h0400), 32'hf);
    end
    sweep_on <= 1'b1;
    xfer(1'b1, ldc_pkg::contrast_addr, 32'h8);
    xfer(1'b1, ldc_pkg::power_duty_addr, 32'h9);
    xfer(1'b1, ldc_pkg::override_addr, 32'h0);
    watch(1'b0);
    xfer(1'b1, ldc_pkg::override_addr, 32'h1);
    watch(1'b1);
    xfer(1'b1, ldc_pkg::override_addr, 32'h2);
    watch(1'b0);
    chk(segment_mode, 32'h1);
    xfer(1'b1, ldc_pkg::override_addr, 32'h5);
    watch(1'b1);
    chk(segment_mode, 32'h2);
    complete_run;
  end
endmodule
`default_nettype wire

// ### ldc_lcd_drive_control.sv
// ldc_lcd_drive_control: control registers and display memory of the lcd drive unit behind apb
// assumes an apb master on pclk; analog bias generation and waveform shaping live outside
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - bias power bit on enables the generator; off grounds every drive level
// - reset clears power, reference, duty, all-lit, page and expansion bits
// - reset sets the all-dark bit so the display starts blank
// - reference bit one picks second-level standard, zero first-level
// - duty: upper bit one 1/8 on 8 commons; 01 1/16; 00 1/17
// - all-lit forces on waveform to segments; display memory left untouched
// - all-dark forces off waveform to segments; display memory left untouched
// - when both overrides are set, all-lit wins
// - in 1/8 duty the page bit picks upper or lower memory half
// - in 1/16 or 1/17 duty the page bit is plain storage
// - four-bit contrast picks one of sixteen levels, 0 lightest, 15 darkest
// - expansion enable bit gates the signals to an external driver
// - a display memory one lights its dot, a zero darkens it
// - display memory sits from the first display address, spare words general storage
// - frame rate 32 Hz at 1/8 and 1/16, 30.12 Hz at 1/17
module ldc_lcd_drive_control #(
  parameter int addr_width = 18
) (
  // apb
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [addr_width-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // scan side: display engine asks for a display word by common and column
  input  wire logic                  scan_req,
  input  wire logic [4:0]            scan_common,
  input  wire logic [5:0]            scan_column,
  output logic                       scan_dot,
  output logic                       scan_valid,
  // analog and panel control
  output logic                       bias_power_on,
  output logic                       reference_level_select,
  output logic [3:0]                 contrast_level,
  output logic [4:0]                 common_count,
  output logic                       frame_17_commons,
  output logic [1:0]                 segment_mode,
  output logic                       expansion_driver_enable
);

  localparam int dmem_words_p = ldc_pkg::dmem_words;

  // software-visible state; contrast and display memory carry no reset
  logic [3:0]  power_duty;
  logic [3:0]  override;
  logic [3:0]  contrast;
  logic [3:0]  dmem [0:dmem_words_p-1];

  // bus decode
  logic        setup;
  logic        access;
  logic        write_take;
  logic        mapped;
  logic        hit_power;
  logic        hit_override;
  logic        hit_contrast;
  logic        hit_dmem;
  logic [9:0]  dmem_index;
  logic        wr_lane;
  logic [31:0] next_rdata;
  // scan path
  logic        next_dot;
  logic [9:0]  scan_index;
  // derived control
  logic [1:0]  duty_code;

  function automatic logic [9:0] word_of(input logic [addr_width-1:0] a);
    logic [addr_width-1:0] d;
    d = a - addr_width'(ldc_pkg::dmem_base_addr);
    word_of = d[11:2];
  endfunction

  function automatic ldc_pkg::ldc_duty_type duty_of(input logic [1:0] bits);
    if (bits[1]) begin
      duty_of = ldc_pkg::ldc_duty_8;
    end else if (bits[0]) begin
      duty_of = ldc_pkg::ldc_duty_16;
    end else begin
      duty_of = ldc_pkg::ldc_duty_17;
    end
  endfunction

  // widen a 4-bit field to a bus word, upper bits read zero
  function automatic logic [31:0] word32(input logic [3:0] f);
    word32 = {28'h0000000, f};
  endfunction

  // decode: read data is fetched in the setup cycle and answered in the access cycle;
  // writes land only at the edge that completes the access, when the master sees pready
  assign setup        = psel && !penable;
  assign access       = psel && penable && pready;
  assign write_take   = access && pwrite && wr_lane;
  assign hit_power    = paddr == addr_width'(ldc_pkg::power_duty_addr);
  assign hit_override = paddr == addr_width'(ldc_pkg::override_addr);
  assign hit_contrast = paddr == addr_width'(ldc_pkg::contrast_addr);
  assign hit_dmem     = paddr >= addr_width'(ldc_pkg::dmem_base_addr) &&
                        paddr <= addr_width'(ldc_pkg::dmem_last_addr) && paddr[1:0] == 2'b00;
  assign dmem_index   = word_of(paddr);
  assign wr_lane      = pstrb[0];
  assign mapped       = hit_power || hit_override || hit_contrast || hit_dmem;
  assign duty_code    = {power_duty[ldc_pkg::duty_hi_pos], power_duty[ldc_pkg::duty_lo_pos]};

  // power and duty register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_duty <= ldc_pkg::power_duty_reset;
    end else if (write_take && hit_power) begin
      power_duty <= pwdata[3:0];
    end
  end

  // override register; page bit stays plain storage outside 1/8 duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      override <= ldc_pkg::override_reset;
    end else if (write_take && hit_override) begin
      override <= pwdata[3:0];
    end
  end

  // contrast has no reset
  always_ff @(posedge pclk) begin
    if (write_take && hit_contrast) begin
      contrast <= pwdata[3:0];
    end
  end

  // display memory, no reset; holes behave as storage, software keeps off them
  always_ff @(posedge pclk) begin
    if (write_take && hit_dmem) begin
      dmem[dmem_index] <= pwdata[3:0];
    end
  end

  // read multiplexer
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_power) begin
      next_rdata = word32(power_duty);
    end else if (hit_override) begin
      next_rdata = word32(override);
    end else if (hit_contrast) begin
      next_rdata = word32(contrast);
    end else if (hit_dmem) begin
      next_rdata = word32(dmem[dmem_index]);
    end
  end

  // handshake: pready stands for exactly the access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // error for addresses outside the map, raised together with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !mapped;
    end
  end

  // read data: registered in setup, zero in every other cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_rdata;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // scan fetch: two words per column, common group picks the block
  // out-of-range fetches clamp to the last word instead of reading past the array
  always_comb begin
    scan_index = {scan_common[4:3] == 2'b10 ? 2'b10 : {1'b0, scan_common[3]}, 1'b0, scan_column, scan_common[2]};
    if (duty_of(duty_code) == ldc_pkg::ldc_duty_8 && override[ldc_pkg::half_screen_pos]) begin
      scan_index = scan_index + ldc_pkg::page_hi_offset;
    end
    if (scan_index > 10'(dmem_words_p - 1)) begin
      scan_index = 10'(dmem_words_p - 1);
    end
    next_dot = dmem[scan_index][scan_common[1:0]];
  end

  // scan answer one cycle after each request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_valid <= 1'b0;
    end else begin
      scan_valid <= scan_req;
    end
  end

  // dot value, held low between requests so unwritten memory never leaks out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_dot <= 1'b0;
    end else begin
      scan_dot <= scan_req && next_dot;
    end
  end

  // generator switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_power_on <= 1'b0;
    end else begin
      bias_power_on <= power_duty[ldc_pkg::bias_power_pos];
    end
  end

  // regulator reference standard
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_level_select <= 1'b0;
    end else begin
      reference_level_select <= power_duty[ldc_pkg::reference_pos];
    end
  end

  // contrast code, forced to the ground level while the generator is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contrast_level <= 4'h0;
    end else begin
      contrast_level <= power_duty[ldc_pkg::bias_power_pos] ? contrast : 4'h0;
    end
  end

  // expansion driver gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expansion_driver_enable <= 1'b0;
    end else begin
      expansion_driver_enable <= override[ldc_pkg::expansion_pos];
    end
  end

  // duty: scanned commons and frame rate class
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      common_count     <= ldc_pkg::commons_full;
      frame_17_commons <= 1'b1;
    end else begin
      unique case (duty_of(duty_code))
        ldc_pkg::ldc_duty_8: begin
          common_count     <= ldc_pkg::commons_eighth;
          frame_17_commons <= 1'b0;
        end
        ldc_pkg::ldc_duty_16: begin
          common_count     <= ldc_pkg::commons_sixteenth;
          frame_17_commons <= 1'b0;
        end
        ldc_pkg::ldc_duty_17: begin
          common_count     <= ldc_pkg::commons_full;
          frame_17_commons <= 1'b1;
        end
        default: begin
          common_count     <= ldc_pkg::commons_full;
          frame_17_commons <= 1'b1;
        end
      endcase
    end
  end

  // segment override; display memory is never touched by it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      segment_mode <= ldc_pkg::ldc_seg_dark;
    end else if (override[ldc_pkg::all_lit_pos]) begin
      segment_mode <= ldc_pkg::ldc_seg_lit;
    end else if (override[ldc_pkg::all_dark_pos]) begin
      segment_mode <= ldc_pkg::ldc_seg_dark;
    end else begin
      segment_mode <= ldc_pkg::ldc_seg_normal;
    end
  end

endmodule
`default_nettype wire

// ### ldc_lcd_drive_control_properties.sv
// checker for the lcd drive control block ports
// assumes one clock pclk and async active-low presetn
`timescale 1ns/100ps
`default_nettype none
module ldc_checker (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  // scan and control
  input wire logic        scan_req,
  input wire logic        scan_valid,
  input wire logic        bias_power_on,
  input wire logic [3:0]  contrast_level,
  input wire logic [4:0]  common_count,
  input wire logic        frame_17_commons,
  input wire logic [1:0]  segment_mode,
  input wire logic        expansion_driver_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic take;
  logic done;
  logic wr_pd;
  logic wr_ov;
  logic mapped;
  assign take = psel && !penable;
  assign done = psel && penable && pready;
  assign wr_pd = done && pwrite && pstrb[0] && paddr == ldc_pkg::power_duty_addr;
  assign wr_ov = done && pwrite && pstrb[0] && paddr == ldc_pkg::override_addr;
  assign mapped = paddr inside {ldc_pkg::power_duty_addr, ldc_pkg::override_addr, ldc_pkg::contrast_addr}
                  || (paddr >= ldc_pkg::dmem_base_addr && paddr <= ldc_pkg::dmem_last_addr && paddr[1:0] == 2'b00);
  a_ready_after_setup: assert property (take |=> pready) else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
  a_error_unmapped: assert property (take |=> pslverr == $past(!mapped)) else $error("pslverr wrong");
  a_power_follows: assert property (wr_pd |-> ##2 bias_power_on == $past(pwdata[0], 2)) else $error("power bit");
  a_duty_count: assert property (wr_pd |-> ##2 common_count == ($past(pwdata[3], 2) ? ldc_pkg::commons_eighth :
    $past(pwdata[2], 2) ? ldc_pkg::commons_sixteenth : ldc_pkg::commons_full)) else $error("duty count");
  a_frame_rate: assert property (frame_17_commons == (common_count == 5'h11)) else $error("frame rate");
  a_seg_priority: assert property (wr_ov |-> ##2 segment_mode == ($past(pwdata[1], 2) ? 2'b01 :
    $past(pwdata[2], 2) ? 2'b10 : 2'b00)) else $error("segment override");
  a_expansion_gate: assert property (wr_ov |-> ##2 expansion_driver_enable == $past(pwdata[3], 2))
    else $error("expansion enable");
  a_contrast_ground: assert property (!bias_power_on |-> contrast_level == 4'h0) else $error("levels not grounded");
  a_scan_answer: assert property (scan_req |=> scan_valid) else $error("no scan answer");
endmodule
bind ldc_lcd_drive_control ldc_checker u_ldc_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .pslverr, .scan_req, .scan_valid, .bias_power_on, .contrast_level, .common_count,
  .frame_17_commons, .segment_mode, .expansion_driver_enable);
`default_nettype wire

// ### ldc_panel_model.sv
// panel side: sweeps commons 0..7 over 60 columns, tallies dots
// assumes the block answers one cycle after each request
`timescale 1ns/100ps
`default_nettype none
module ldc_panel_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // sweep only once display memory holds known data
  input  wire logic        sweep_on,
  // scan port
  output logic             scan_req,
  output logic [4:0]       scan_common,
  output logic [5:0]       scan_column,
  input  wire logic        scan_dot,
  input  wire logic        scan_valid,
  // tallies
  output logic [15:0]      lit_seen,
  output logic [15:0]      dark_seen
);
  // commons 0..7 exist in every duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_req <= 1'b0;
      scan_common <= 5'h00;
      scan_column <= 6'h00;
    end else begin
      scan_req <= sweep_on;
      scan_column <= (scan_column == 6'h3b) ? 6'h00 : scan_column + 6'h01;
      scan_common <= (scan_column == 6'h3b) ? {2'b00, scan_common[2:0] + 3'h1} : scan_common;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lit_seen <= 16'h0000;
      dark_seen <= 16'h0000;
    end else if (scan_valid) begin
      lit_seen <= lit_seen + {15'h0000, scan_dot};
      dark_seen <= dark_seen + {15'h0000, !scan_dot};
    end
  end
endmodule
`default_nettype wire

// ### ldc_pkg.sv
// ldc_pkg: register map, field positions, reset values and duty codes of the lcd drive control block
// assumes a 32-bit apb slave with one aligned word per register
package ldc_pkg;
  // register indices (printed offsets are not multiples of four), byte address = 4 * index
  localparam logic [15:0] power_duty_index = 16'hff60;
  localparam logic [15:0] override_index   = 16'hff61;
  localparam logic [15:0] contrast_index   = 16'hff62;
  localparam logic [17:0] power_duty_addr  = {power_duty_index, 2'b00};
  localparam logic [17:0] override_addr    = {override_index, 2'b00};
  localparam logic [17:0] contrast_addr    = {contrast_index, 2'b00};
  // display memory window, in data-memory words
  localparam logic [15:0] dmem_base_index  = 16'hf000;
  localparam logic [15:0] dmem_last_index  = 16'hf276;
  localparam logic [17:0] dmem_base_addr   = {dmem_base_index, 2'b00};
  localparam logic [17:0] dmem_last_addr   = {dmem_last_index, 2'b00};
  localparam int          dmem_words       = 16'h0277;
  // upper half base for 1/8 duty page select
  localparam logic [9:0]  page_hi_offset   = 10'h100;
  // field positions, power/duty register
  localparam int bias_power_pos     = 0;
  localparam int reference_pos      = 1;
  localparam int duty_lo_pos        = 2;
  localparam int duty_hi_pos        = 3;
  // field positions, override register
  localparam int half_screen_pos    = 0;
  localparam int all_lit_pos        = 1;
  localparam int all_dark_pos       = 2;
  localparam int expansion_pos      = 3;
  // reset values
  localparam logic [3:0] power_duty_reset = 4'h0;
  localparam logic [3:0] override_reset   = 4'h4;
  // common line counts per duty
  localparam logic [4:0] commons_eighth    = 5'h08;
  localparam logic [4:0] commons_sixteenth = 5'h10;
  localparam logic [4:0] commons_full      = 5'h11;
  typedef enum logic [1:0] {
    ldc_duty_17 = 2'b00,
    ldc_duty_16 = 2'b01,
    ldc_duty_8  = 2'b10
  } ldc_duty_type;
  typedef enum logic [1:0] {
    ldc_seg_normal = 2'b00,
    ldc_seg_lit    = 2'b01,
    ldc_seg_dark   = 2'b10
  } ldc_seg_mode_type;
endpackage
